// File: hw/rsp_consts.svh
// Constants for the return stack pointer control block: register offsets,
// field positions, reset values and the pointer limits.
// Assumes inclusion by bare name from the package and the design module.
`ifndef RSP_CONSTS_SVH
`define RSP_CONSTS_SVH

// Register byte offsets on the APB slave
`define RSP_OFF_POINTER 8'h00
`define RSP_OFF_CONFIG 8'h04
`define RSP_OFF_IRQ_STATUS 8'h08
`define RSP_OFF_IRQ_ENABLE 8'h0c
`define RSP_OFF_IRQ_CLEAR 8'h10
`define RSP_OFF_TOP_ENTRY 8'h14
// Address bits that take part in the register decode
`define RSP_OFF_BITS 8

// Pointer register field positions
`define RSP_BIT_FULL 7
`define RSP_BIT_UNDERFLOW 6
`define RSP_PTR_MSB 4
`define RSP_PTR_LSB 0

// Configuration and interrupt field positions
`define RSP_BIT_OVF_RST_EN 0
`define RSP_IRQ_FULL 0
`define RSP_IRQ_UNDERFLOW 1

// Pointer limits and values
`define RSP_PTR_EMPTY 5'h00
`define RSP_PTR_TOP 5'h1f
`define RSP_PTR_STEP 5'h01

// Reset values
`define RSP_OVF_RST_EN_RESET 1'b1
`define RSP_IRQ_RESET 2'h0

// Offset added to the program counter on the overflowing push
`define RSP_PC_STEP 2

`endif

// File: hw/rsp_pkg.sv
// Types shared by the return stack pointer control block.
// Assumes rsp_consts.svh sits on the include path.
`include "rsp_consts.svh"

package rsp_pkg;

	// Five-bit stack pointer, values 0 to 31
	typedef logic [4:0] ptr_t;

	// Register selected by an APB address
	typedef enum logic [2:0] {
		REG_POINTER,
		REG_CONFIG,
		REG_IRQ_STATUS,
		REG_IRQ_ENABLE,
		REG_IRQ_CLEAR,
		REG_TOP_ENTRY,
		REG_NONE
	} reg_e;

endpackage : rsp_pkg

// File: hw/return_stack_pointer_control.sv
// Return stack pointer control: pointer, full and underflow flags, the
// overflow reset option, the return stack storage and an APB register slave.
// Assumes the core issues push and pop as one-cycle pulses on clk, never both
// at once, and that a device reset request is fed back into rst by the system.
//
// Overview of operation
// - Pointer holds only values 0 to 31.
// - Push increments then writes; pop reads then decrements.
// - Any device reset clears the pointer.
// - Software reads and writes the pointer.
// - Full flag sets after 31 pushes.
// - Full flag cleared only by software or power-on.
// - Reset enabled: 31st push stores PC+2, resets.
// - Reset disabled: pointer stops at 31, entry kept.
// - Pop on empty returns zero, sets underflow.
// - Underflow flag cleared by software or power-on.
// - Underflow only redirects to zero, no reset.
// - Register bits: full 7, underflow 6, pointer 4:0.
// - Software push/pop move pointer like calls/returns.
`timescale 1ns/10ps
`include "rsp_consts.svh"

module return_stack_pointer_control
	import rsp_pkg::*;
#(
	parameter int PC_WIDTH = 21, // Program counter width
	parameter int ADDR_WIDTH = 8 // APB address width
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic porRst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pushReq,
	input wire logic popReq,
	input wire logic [PC_WIDTH-1:0] pcValue,
	output logic [PC_WIDTH-1:0] popPcValue,
	output logic popDone,
	output logic [PC_WIDTH-1:0] topOfStackEntry,
	output logic deviceResetReq,
	output logic irq
);

	// Whole block state, registered in one place
	typedef struct packed {
		logic [31:0][PC_WIDTH-1:0] stack; // Entry 0 is never written
		ptr_t ptr; // Pointer value field
		logic stackFullFlag; // Sticky full flag
		logic stackUnderflowFlag; // Sticky underflow flag
		logic overflowResetEnable; // Overflow reset option
		logic [1:0] irqStatus; // Sticky interrupt events
		logic [1:0] irqEnable; // Interrupt mask
		logic irqOut; // Registered interrupt level
		logic apbReady; // High in the access cycle
		logic apbError; // Unmapped address answer
		logic [31:0] apbRdata; // Read data captured in setup
		logic [PC_WIDTH-1:0] popValue; // Value returned by the last pop
		logic popStrobe; // One-cycle pop completion
		logic [PC_WIDTH-1:0] topEntry; // Entry under the pointer
		logic resetReq; // One-cycle overflow reset request
	} state_s;

	state_s s_q; // Registered state
	state_s s_d; // Next state

	// Map an APB address onto a register; reused by read and write paths
	function automatic reg_e decodeReg(input logic [ADDR_WIDTH-1:0] addr);
		reg_e sel;
		sel = REG_NONE;
		// Only aligned words hit; byte lanes are not decoded
		case (addr[`RSP_OFF_BITS-1:0])
			`RSP_OFF_POINTER: sel = REG_POINTER;
			`RSP_OFF_CONFIG: sel = REG_CONFIG;
			`RSP_OFF_IRQ_STATUS: sel = REG_IRQ_STATUS;
			`RSP_OFF_IRQ_ENABLE: sel = REG_IRQ_ENABLE;
			`RSP_OFF_IRQ_CLEAR: sel = REG_IRQ_CLEAR;
			`RSP_OFF_TOP_ENTRY: sel = REG_TOP_ENTRY;
			default: sel = REG_NONE;
		endcase
		// Upper address bits must be zero for a hit
		if ((addr >> `RSP_OFF_BITS) != '0)
		begin
			sel = REG_NONE;
		end
		return sel;
	endfunction : decodeReg

	// Pack the pointer register image
	function automatic logic [31:0] pointerImage(input state_s st);
		logic [31:0] img;
		img = 32'h0;
		img[`RSP_BIT_FULL] = st.stackFullFlag;
		img[`RSP_BIT_UNDERFLOW] = st.stackUnderflowFlag;
		img[`RSP_PTR_MSB:`RSP_PTR_LSB] = st.ptr;
		return img;
	endfunction : pointerImage

	// Request decode for this cycle
	logic apbSetup; // First cycle of a transfer
	logic apbDone; // Access completes at this edge
	reg_e apbSel; // Register addressed now
	logic fullEvent; // Full flag set this cycle
	logic underflowEvent; // Underflow flag set this cycle
	ptr_t nextPtr; // Pointer after an increment

	// Read data is captured only in the setup cycle
	assign apbSetup = psel && !penable;
	assign apbDone = psel && penable && s_q.apbReady;
	assign apbSel = decodeReg(paddr);
	// Wraps past 31, but the push branches never store that wrap
	assign nextPtr = ptr_t'(s_q.ptr + `RSP_PTR_STEP);

	// Next-state logic: core stack events, register access, resets
	always_comb
	begin
		s_d = s_q;
		s_d.popStrobe = 1'b0;
		s_d.resetReq = 1'b0;
		fullEvent = 1'b0;
		underflowEvent = 1'b0;

		// Software writes: pointer, flags clear, config, mask, event clear
		if (apbDone && pwrite)
		begin
			case (apbSel)
				REG_POINTER:
				begin
					s_d.ptr = pwdata[`RSP_PTR_MSB:`RSP_PTR_LSB];
					if (!pwdata[`RSP_BIT_FULL])
					begin
						s_d.stackFullFlag = 1'b0;
					end
					if (!pwdata[`RSP_BIT_UNDERFLOW])
					begin
						s_d.stackUnderflowFlag = 1'b0;
					end
				end
				REG_CONFIG:
				begin
					// Option survives a device reset; only power-on sets it back
					s_d.overflowResetEnable = pwdata[`RSP_BIT_OVF_RST_EN];
				end
				REG_IRQ_ENABLE:
				begin
					// Mask is cleared by any device reset
					s_d.irqEnable = pwdata[`RSP_IRQ_UNDERFLOW:`RSP_IRQ_FULL];
				end
				REG_IRQ_CLEAR:
				begin
					// Write one to clear; a new event below still wins
					s_d.irqStatus = s_q.irqStatus & ~pwdata[`RSP_IRQ_UNDERFLOW:`RSP_IRQ_FULL];
				end
				default:
				begin
					// Read-only or unmapped: nothing stored
				end
			endcase
		end

		// Core push, used by calls, interrupts and software push alike
		if (pushReq)
		begin
			if (s_q.ptr == `RSP_PTR_TOP)
			begin
				// pointer parked at 31, entry kept
				// Refused push: nothing stored, the flag is set again
				fullEvent = 1'b1;
				s_d.ptr = `RSP_PTR_TOP;
			end
			else if (nextPtr == `RSP_PTR_TOP && s_q.overflowResetEnable)
			begin
				s_d.stack[nextPtr] = PC_WIDTH'(pcValue + `RSP_PC_STEP);
				fullEvent = 1'b1;
				s_d.ptr = `RSP_PTR_EMPTY;
				// Pointer is already zero when the system reset lands
				s_d.resetReq = 1'b1;
			end
			else
			begin
				s_d.stack[nextPtr] = pcValue;
				s_d.ptr = nextPtr;
				if (nextPtr == `RSP_PTR_TOP)
				begin
					fullEvent = 1'b1;
				end
			end
		end
		else if (popReq)
		begin
			s_d.popStrobe = 1'b1;
			if (s_q.ptr == `RSP_PTR_EMPTY)
			begin
				// no reset, only a zero vector
				s_d.popValue = '0;
				underflowEvent = 1'b1;
				// Pointer stays at zero; it never wraps to 31
				s_d.ptr = `RSP_PTR_EMPTY;
			end
			else
			begin
				s_d.popValue = s_q.stack[s_q.ptr];
				s_d.ptr = ptr_t'(s_q.ptr - `RSP_PTR_STEP);
			end
		end

		// Hardware set wins over a software clear in the same cycle
		if (fullEvent)
		begin
			s_d.stackFullFlag = 1'b1;
			s_d.irqStatus[`RSP_IRQ_FULL] = 1'b1;
		end
		if (underflowEvent)
		begin
			s_d.stackUnderflowFlag = 1'b1;
			s_d.irqStatus[`RSP_IRQ_UNDERFLOW] = 1'b1;
		end

		// APB handshake: one wait-free access phase after each setup
		if (apbSetup)
		begin
			s_d.apbReady = 1'b1;
			s_d.apbError = (apbSel == REG_NONE);
			case (apbSel)
				REG_POINTER: s_d.apbRdata = pointerImage(s_q);
				REG_CONFIG: s_d.apbRdata = 32'(s_q.overflowResetEnable);
				REG_IRQ_STATUS: s_d.apbRdata = 32'(s_q.irqStatus);
				REG_IRQ_ENABLE: s_d.apbRdata = 32'(s_q.irqEnable);
				REG_TOP_ENTRY: s_d.apbRdata = 32'(s_q.stack[s_q.ptr]);
				default: s_d.apbRdata = 32'h0;
			endcase
		end
		else if (apbDone)
		begin
			s_d.apbReady = 1'b0;
			s_d.apbError = 1'b0;
		end

		// Device reset: pointer, bus and interrupt logic; flags survive it
		if (rst)
		begin
			// Stack contents stay, only the pointer into them is lost
			// reset clears the pointer
			s_d.ptr = `RSP_PTR_EMPTY;
			s_d.irqStatus = `RSP_IRQ_RESET;
			s_d.irqEnable = `RSP_IRQ_RESET;
			s_d.apbReady = 1'b0;
			s_d.apbError = 1'b0;
			s_d.apbRdata = 32'h0;
			s_d.popStrobe = 1'b0;
			s_d.resetReq = 1'b0;
			s_d.popValue = '0;
		end

		// Power-on reset clears everything, flags too, and sets the option back to 1
		if (porRst)
		begin
			// Wins over a device reset in the same cycle
			s_d = '0;
			s_d.overflowResetEnable = `RSP_OVF_RST_EN_RESET;
		end

		s_d.topEntry = s_d.stack[s_d.ptr];
		// Built from the next state, so irq has no extra cycle of lag
		s_d.irqOut = |(s_d.irqStatus & s_d.irqEnable);
	end

	// Single state register; all resets are synchronous
	// Both resets sit in the next-state logic, so no reset branch here
	always_ff @(posedge clk)
	begin
		s_q <= s_d;
	end

	// Outputs come straight from the state register
	// Bus answers are registered, hence pready one cycle after setup
	assign prdata = s_q.apbRdata;
	assign pready = s_q.apbReady;
	assign pslverr = s_q.apbError;
	assign popPcValue = s_q.popValue;
	assign popDone = s_q.popStrobe;
	assign topOfStackEntry = s_q.topEntry;
	assign deviceResetReq = s_q.resetReq;
	assign irq = s_q.irqOut;

endmodule : return_stack_pointer_control

// File: sim/core_seq_model.sv
// Model of the core's call and return sequencing: push and pop pulses.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/10ps
module core_seq_model
	import rsp_pkg::*;
#(parameter int PC_WIDTH = 21)
(
	input wire logic clk,
	output logic pushReq,
	output logic popReq,
	output logic [PC_WIDTH-1:0] pcValue
);
	// Idle: no request, PC pattern of no meaning
	initial
	begin
		pushReq = 1'h0;
		popReq = 1'h0;
		pcValue = '0;
	end

	// One-cycle push with the PC; a spare edge keeps pulses apart
	task automatic push(input logic [PC_WIDTH-1:0] pc);
		pushReq <= 1'h1;
		pcValue <= pc;
		@(posedge clk);
		pushReq <= 1'h0;
		// Stale PC is inverted so nothing can lean on it
		pcValue <= ~pc;
		@(posedge clk);
	endtask : push

	// One-cycle pop, result read by the bench afterwards
	task automatic pop();
		popReq <= 1'h1;
		@(posedge clk);
		popReq <= 1'h0;
		@(posedge clk);
	endtask : pop
endmodule : core_seq_model

// File: sim/rsp_assertions.sv
// Checker for the return stack pointer block: APB timing, pop and reset pulses.
// Assumes it is bound to the block's top module and sees only its ports.
`timescale 1ns/10ps
module return_stack_pointer_control_checker
	import rsp_pkg::*;
#(parameter int PC_WIDTH = 21)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic porRst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pushReq,
	input wire logic popReq,
	input wire logic [PC_WIDTH-1:0] popPcValue,
	input wire logic popDone,
	input wire logic deviceResetReq,
	input wire logic irq
);
	// One clock domain; either reset silences every check
	default clocking @(posedge clk); endclocking
	default disable iff (rst || porRst);

	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer without ready or with data");
	a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside a setup");
	a_pop_answer: assert property (popReq && !pushReq |=> popDone)
		else $error("pop not answered next cycle");
	// A reset in the previous cycle may clear the value, so skip that edge
	a_pop_hold: assert property (!popDone && !$past(rst) && !$past(porRst) |-> $stable(popPcValue))
		else $error("popped value moved without a pop");
	a_rstreq_cause: assert property (deviceResetReq |-> $past(pushReq) ##1 !deviceResetReq)
		else $error("reset request without push or too long");
	a_irq_quiet: assert property ($fell(rst) |-> !irq)
		else $error("interrupt high after device reset");
endmodule : return_stack_pointer_control_checker

bind return_stack_pointer_control return_stack_pointer_control_checker
	#(.PC_WIDTH(PC_WIDTH)) u_chk (.clk, .rst, .porRst, .psel, .penable, .prdata,
	.pready, .pslverr, .pushReq, .popReq, .popPcValue, .popDone, .deviceResetReq, .irq);

// File: sim/return_stack_pointer_control_tb.sv
// Bench for the return stack pointer block: APB master, scenarios, verdict.
// Assumes the core model drives push/pop and the bench pulses rst on requests.
`timescale 1ns/10ps
`include "rsp_consts.svh"
module return_stack_pointer_control_tb
	import rsp_pkg::*;
;
	logic clk = 1'h0, rst = 1'h1, porRst = 1'h1, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, err, pushReq, popReq, popDone, irq;
	logic deviceResetReq;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [20:0] pcValue, popPcValue, topOfStackEntry;
	int n_mismatch = 0, n_tests = 0, cyc = 0, nRstReq = 0;

	always #4 clk = ~clk;

	return_stack_pointer_control dut (.clk, .rst, .porRst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pushReq, .popReq, .pcValue,
		.popPcValue, .popDone, .topOfStackEntry, .deviceResetReq, .irq);
	core_seq_model core (.clk, .pushReq, .popReq, .pcValue);

	// Count reset requests; cut a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (deviceResetReq === 1'h1)
			nRstReq <= nRstReq + 1;
		if (cyc == 4000)
		begin
			n_mismatch++;
			close_out();
		end
	end

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk

	// APB transfer held until pready is sampled high
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Idle edge: the next call never re-drives psel in this step
		@(posedge clk);
	endtask : apb

	task automatic rdc(string w, logic [7:0] a, logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(w, rd, e);
	endtask : rdc

	task automatic pulse_rst();
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
	endtask : pulse_rst

	task automatic t_basic();
		rdc("ptr", `RSP_OFF_POINTER, 32'h0);
		rdc("cfg", `RSP_OFF_CONFIG, 32'h1);
		apb(1'h0, 8'h18, 32'h0);
		chk("err", err, 32'h1);
		chk("rdata", rd, 32'h0);
	endtask : t_basic

	task automatic t_stack();
		core.push(21'h01234);
		core.push(21'h0abcd);
		chk("top", topOfStackEntry, 32'h0abcd);
		rdc("ptr", `RSP_OFF_POINTER, 32'h2);
		core.pop();
		chk("pop", popPcValue, 32'h0abcd);
		chk("top", topOfStackEntry, 32'h01234);
		rdc("ptr", `RSP_OFF_POINTER, 32'h1);
	endtask : t_stack

	task automatic t_under();
		apb(1'h1, `RSP_OFF_IRQ_ENABLE, 32'h2);
		core.pop();
		core.pop();
		chk("pop", popPcValue, 32'h0);
		rdc("ptr", `RSP_OFF_POINTER, 32'h40);
		rdc("ist", `RSP_OFF_IRQ_STATUS, 32'h2);
		chk("req", nRstReq, 32'h0);
		rdc("ien", `RSP_OFF_IRQ_ENABLE, 32'h2);
		chk("irq", irq, 32'h1);
		apb(1'h1, `RSP_OFF_IRQ_CLEAR, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq", irq, 32'h0);
		pulse_rst();
		rdc("ptr", `RSP_OFF_POINTER, 32'h40);
		apb(1'h1, `RSP_OFF_POINTER, 32'h0);
		rdc("ptr", `RSP_OFF_POINTER, 32'h0);
	endtask : t_under

	task automatic t_full();
		apb(1'h1, `RSP_OFF_CONFIG, 32'h0);
		for (int i = 1; i <= 31; i++)
			core.push(21'(i));
		rdc("ptr", `RSP_OFF_POINTER, 32'h9f);
		core.push(21'h1ffff);
		rdc("ptr", `RSP_OFF_POINTER, 32'h9f);
		rdc("top", `RSP_OFF_TOP_ENTRY, 32'h1f);
		rdc("ist", `RSP_OFF_IRQ_STATUS, 32'h1);
		chk("irq", irq, 32'h0);
		pulse_rst();
		rdc("ptr", `RSP_OFF_POINTER, 32'h80);
	endtask : t_full

	task automatic t_ovf();
		apb(1'h1, `RSP_OFF_CONFIG, 32'h1);
		apb(1'h1, `RSP_OFF_POINTER, 32'h1e);
		core.push(21'h00100);
		pulse_rst();
		chk("req", nRstReq, 32'h1);
		rdc("ptr", `RSP_OFF_POINTER, 32'h80);
		apb(1'h1, `RSP_OFF_POINTER, 32'h9f);
		rdc("top", `RSP_OFF_TOP_ENTRY, 32'h102);
	endtask : t_ovf

	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		porRst <= 1'h0;
		@(posedge clk);
		t_basic();
		t_stack();
		t_under();
		t_full();
		t_ovf();
		close_out();
	end
endmodule : return_stack_pointer_control_tb
